// file: src/prs_por_sleep.v
// Power-on reset timer and HALT/STOP sleep sequencer
`include "prs_defines.vh"
module prs_por_sleep #(
  parameter DELAY_TICKS = (`PRS_DELAY_US * (`PRS_RC_HZ / 1000) + 999) / 1000,
  parameter RC_DIV = `PRS_RC_DIV
) (
  input wire clock,
  input wire nrst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  input wire power_good,
  input wire ext_reset,
  input wire stop_recovery_event,
  input wire watchdog_timeout,
  input wire [5:0] irq_in,
  input wire [5:0] irq_enable,
  input wire irq_serviced,
  input wire [7:0] last_opcode,
  output wire cpu_run,
  output wire cpu_clk_en,
  output wire xtal_en,
  output wire timers_en,
  output wire [5:0] irq_pending,
  output wire [15:0] restart_addr,
  output wire restart_load,
  output wire [7:0] watchdog_timer_control
);
  // ********************************
  // Pin synchronisers
  // ********************************
  // The supply, reset, recovery, watchdog and irq_in pins are asynchronous to the clock, so each bit passes two flops
  localparam PIN_W = 10;
  wire [PIN_W-1:0] pin_raw;
  wire [PIN_W-1:0] pin_sync;
  assign pin_raw = {power_good, ext_reset, stop_recovery_event, watchdog_timeout, irq_in};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
      reg meta_reg;
      reg stable_reg;

      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          meta_reg <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg <= pin_raw[gi];
          stable_reg <= meta_reg;
        end
      end

      // Only the second flop leaves this block
      assign pin_sync[gi] = stable_reg;
    end
  endgenerate

  wire pg_s;
  wire xr_s;
  wire sr_s;
  wire wd_s;
  wire [5:0] irq_sync;

  assign pg_s = pin_sync[9];
  assign xr_s = pin_sync[8];
  assign sr_s = pin_sync[7];
  assign wd_s = pin_sync[6];
  assign irq_sync = pin_sync[5:0];

  // ********************************
  // Edge detectors
  // ********************************
  reg pg_d_reg;
  reg sr_d_reg;
  reg wd_d_reg;
  wire pg_rise;
  wire sr_rise;
  wire wd_rise;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pg_d_reg <= 1'b0;
      sr_d_reg <= 1'b0;
      wd_d_reg <= 1'b0;
    end else begin
      pg_d_reg <= pg_s;
      sr_d_reg <= sr_s;
      wd_d_reg <= wd_s;
    end
  end

  // Supply already good at release counts as a rise and restarts the delay
  assign pg_rise = pg_s & ~pg_d_reg;
  assign sr_rise = sr_s & ~sr_d_reg;
  assign wd_rise = wd_s & ~wd_d_reg;

  // ********************************
  // Registers
  // ********************************
  reg [7:0] smr_reg;
  reg [7:0] wdt_reg;
  wire smr_wr;
  wire wdt_wr;
  wire cmd_wr;

  assign smr_wr = wr_stb && (addr == `PRS_ADDR_STOP_RECOVERY);
  assign wdt_wr = wr_stb && (addr == `PRS_ADDR_WDT_CTRL);
  assign cmd_wr = wr_stb && (addr == `PRS_ADDR_CMD);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      smr_reg <= `PRS_SMR_RESET;
    end else if (smr_wr) begin
      smr_reg <= wdata;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wdt_reg <= `PRS_WDT_CTRL_RESET;
    end else if (wdt_wr) begin
      wdt_reg <= wdata;
    end
  end

  // ********************************
  // RC tick divider
  // ********************************
  // Stands in for the dedicated RC oscillator as a one-cycle enable
  reg [7:0] div_reg;
  wire rc_tick;

  assign rc_tick = (div_reg == RC_DIV[7:0] - 8'h01);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= rc_tick ? 8'h00 : div_reg + 8'h01;
    end
  end

  // ********************************
  // Request decode
  // ********************************
  // Sleep only accepted after a pipeline-flushing no-op
  wire flushed;
  wire halt_req;
  wire stop_req;
  wire irq_wake;
  wire reset_ev;
  wire delay_done;

  assign flushed = (last_opcode == `PRS_NOP_OPCODE);
  assign halt_req = cmd_wr && flushed && (wdata == `PRS_CMD_HALT);
  assign stop_req = cmd_wr && flushed && (wdata == `PRS_CMD_STOP);
  assign irq_wake = irq_serviced && |(irq_sync & irq_enable);
  assign reset_ev = pg_rise | wd_rise | xr_s;

  // ********************************
  // Sequencer
  // ********************************
  localparam ST_RUN = 4'b0001;
  localparam ST_HALT = 4'b0010;
  localparam ST_STOP = 4'b0100;
  localparam ST_DELAY = 4'b1000;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg restart_reg;
  reg restart_next;

  // One tick beyond the count, as the first tick may end a partial period
  assign delay_done = rc_tick && (cnt_reg == DELAY_TICKS[15:0]);

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    restart_next = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (stop_req)
          state_next = ST_STOP;
        else if (halt_req)
          state_next = ST_HALT;
      end

      ST_HALT: begin
        // Crystal and timers keep running, only the processor waits
        if (irq_wake)
          state_next = ST_RUN;
      end

      ST_STOP: begin
        if (sr_rise) begin
          restart_next = 1'b1;
          if (smr_reg[`PRS_RECOVERY_DELAY_BIT]) begin
            state_next = ST_DELAY;
            cnt_next = 16'h0000;
          end else begin
            state_next = ST_RUN;
          end
        end
      end

      ST_DELAY: begin
        if (delay_done)
          state_next = ST_RUN;
        else if (rc_tick)
          cnt_next = cnt_reg + 16'h0001;
      end

      default: begin
        state_next = ST_DELAY;
        cnt_next = 16'h0000;
      end
    endcase

    // Any reset source leaves STOP or HALT and restarts the delay
    if (reset_ev) begin
      state_next = ST_DELAY;
      cnt_next = 16'h0000;
      restart_next = (state_reg == ST_STOP);
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_DELAY;
      cnt_reg <= 16'h0000;
      restart_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      restart_reg <= restart_next;
    end
  end

  // ********************************
  // Read port
  // ********************************
  // Watchdog control is write only and reads as zero
  reg [7:0] rdata_next;

  always @* begin
    rdata_next = 8'h00;
    if (rd_stb) begin
      case (addr)
        `PRS_ADDR_STOP_RECOVERY: begin
          rdata_next = smr_reg;
        end
        `PRS_ADDR_STATUS: begin
          rdata_next = {4'h0, state_reg};
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // Data stand for one cycle only, then fall back to zero
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  wire in_run;
  wire in_stop;

  assign in_run = (state_reg == ST_RUN);
  assign in_stop = (state_reg == ST_STOP);

  assign cpu_run = in_run;
  assign cpu_clk_en = in_run;
  assign xtal_en = ~in_stop;
  assign timers_en = ~in_stop;
  assign irq_pending = irq_sync & irq_enable;
  assign restart_addr = `PRS_RESUME_ADDR;
  assign restart_load = restart_reg;
  assign watchdog_timer_control = wdt_reg;

endmodule // prs_por_sleep

// file: src/prs_defines.vh
// Register offsets, field positions and timing counts for the reset and sleep sequencer
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH
// ********************************
// Register map
// ********************************
`define PRS_ADDR_WDT_CTRL 8'h0f
`define PRS_ADDR_STOP_RECOVERY 8'h0b
`define PRS_ADDR_STATUS 8'h0c
`define PRS_ADDR_CMD 8'h0d
// ********************************
// Fields
// ********************************
`define PRS_RECOVERY_DELAY_BIT 5
`define PRS_SMR_RESET 8'h20
`define PRS_WDT_CTRL_RESET 8'h00
`define PRS_CMD_HALT 8'h01
`define PRS_CMD_STOP 8'h02
`define PRS_RESUME_ADDR 16'h000c
`define PRS_NOP_OPCODE 8'hff
// ********************************
// Timing
// ********************************
`define PRS_DELAY_US 2500
`define PRS_RC_HZ 1000000
`define PRS_RC_DIV 125
`endif

// file: tb/prs_checker.sv
// Assertion checker for the reset and sleep sequencer
module prs_checker (
  input wire clock,
  input wire nrst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire [7:0] last_opcode,
  input wire watchdog_timeout,
  input wire cpu_run,
  input wire cpu_clk_en,
  input wire xtal_en,
  input wire timers_en,
  input wire [15:0] restart_addr,
  input wire restart_load
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Legal sleep request, opcode flushed first
  sequence s_go;
    wr_stb && addr == 8'h0d && last_opcode == 8'hff && cpu_run;
  endsequence
  a_clk_gate: assert property (cpu_clk_en == cpu_run) else $error("clock gate off run");
  a_timer_xtal: assert property (timers_en == xtal_en) else $error("timers off in halt");
  a_stop_idle: assert property (!xtal_en |-> !cpu_run) else $error("run with xtal off");
  a_halt_entry: assert property (s_go ##0 wdata == 8'h01 |=> !cpu_clk_en && xtal_en)
    else $error("halt entry wrong");
  a_stop_entry: assert property (s_go ##0 wdata == 8'h02 |=> !xtal_en && !cpu_run)
    else $error("stop entry wrong");
  a_restart_vec: assert property (restart_load |-> restart_addr == 16'h000c)
    else $error("restart vector wrong");
  a_load_once: assert property (restart_load |=> !restart_load) else $error("load too long");
  // Two cycles of sync and one of state before the delay can show
  a_wdt_hold: assert property ($rose(watchdog_timeout) |-> ##[1:5] !cpu_run)
    else $error("watchdog ignored");
endmodule // prs_checker
bind prs_por_sleep prs_checker u_chk (
  .clock(clock),
  .nrst(nrst),
  .addr(addr),
  .wdata(wdata),
  .wr_stb(wr_stb),
  .last_opcode(last_opcode),
  .watchdog_timeout(watchdog_timeout),
  .cpu_run(cpu_run),
  .cpu_clk_en(cpu_clk_en),
  .xtal_en(xtal_en),
  .timers_en(timers_en),
  .restart_addr(restart_addr),
  .restart_load(restart_load)
);

// file: tb/tb.sv
// Self-checking bench for the reset and sleep sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg clock = 0, nrst = 0, wr_stb = 0, rd_stb = 0, power_good = 1, ext_reset = 0;
  reg stop_recovery_event = 0, watchdog_timeout = 0, irq_serviced = 0;
  reg [7:0] addr = 8'h00, wdata = 8'h00, last_opcode = 8'hff;
  reg [5:0] irq_in = 6'h00, irq_enable = 6'h00;
  wire [7:0] rdata, watchdog_timer_control;
  wire cpu_run, cpu_clk_en, xtal_en, timers_en, restart_load;
  wire [5:0] irq_pending;
  wire [15:0] restart_addr;
  integer err_total = 0, samples_checked = 0, n;
  always #4 clock = ~clock;
  // Short delay keeps the run small: 5 ticks of 2 clocks
  prs_por_sleep #(.DELAY_TICKS(4), .RC_DIV(2)) dut (
    .clock(clock),
    .nrst(nrst),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .power_good(power_good),
    .ext_reset(ext_reset),
    .stop_recovery_event(stop_recovery_event),
    .watchdog_timeout(watchdog_timeout),
    .irq_in(irq_in),
    .irq_enable(irq_enable),
    .irq_serviced(irq_serviced),
    .last_opcode(last_opcode),
    .cpu_run(cpu_run),
    .cpu_clk_en(cpu_clk_en),
    .xtal_en(xtal_en),
    .timers_en(timers_en),
    .irq_pending(irq_pending),
    .restart_addr(restart_addr),
    .restart_load(restart_load),
    .watchdog_timer_control(watchdog_timer_control)
  );
  task chk(input string nm, input [15:0] e, input [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0s exp %h got %h", nm, e, g);
    end
  endtask
  task stop_test;
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clock);
    wr_stb <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_stb <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge clock);
    rd_stb <= 1;
    addr <= a;
    @(posedge clock);
    rd_stb <= 0;
    #1 chk("rdata", e, rdata);
  endtask
  // Sampled 1 ns after the edge so the design's updates land first
  task waitfor(input bit sel);
    n = 0;
    while ((sel ? restart_load : cpu_run) !== 1'b1) begin
      @(posedge clock);
      #1 n++;
      if (n > 200) begin
        err_total++;
        stop_test;
      end
    end
  endtask
  task t_por;
    #1 chk("run", 0, cpu_run);
    waitfor(0);
    chk("delay", 1, n >= 8);
  endtask
  task t_regs;
    rd(8'h0b, 8'h20);
    rd(8'h0c, 8'h01);
    rd(8'h0f, 8'h00);
    rd(8'h55, 8'h00);
  endtask
  task t_halt;
    wr(8'h0d, 8'h01);
    #1 chk("halt", 3'b011, {cpu_clk_en, xtal_en, timers_en});
    rd(8'h0c, 8'h02);
    irq_in <= 6'h04;
    irq_enable <= 6'h04;
    repeat (4) @(posedge clock);
    #1 chk("pend", 6'h04, {cpu_run, irq_pending});
    @(posedge clock);
    irq_serviced <= 1;
    waitfor(0);
    chk("wake", 1, n <= 2);
    @(posedge clock);
    irq_serviced <= 0;
    irq_in <= 6'h00;
  endtask
  // Source 0 stop recovery, 1 watchdog, 2 external reset
  task t_stop(input [7:0] stop_recovery_control, input [1:0] src, input bit slow);
    wr(8'h0b, stop_recovery_control);
    wr(8'h0d, 8'h02);
    #1 chk("stop", 0, {xtal_en, cpu_run});
    @(posedge clock);
    irq_in <= 6'h04;
    irq_serviced <= 1;
    repeat (4) @(posedge clock);
    #1 chk("stay", 16'h0004, {xtal_en, cpu_run, restart_load, irq_pending});
    @(posedge clock);
    irq_serviced <= 0;
    irq_in <= 6'h00;
    if (src == 2'd1) watchdog_timeout <= 1;
    else if (src == 2'd2) ext_reset <= 1;
    else stop_recovery_event <= 1;
    waitfor(1);
    chk("vec", 16'h000c, restart_addr);
    @(posedge clock);
    watchdog_timeout <= 0;
    ext_reset <= 0;
    stop_recovery_event <= 0;
    waitfor(0);
    chk("wait", slow, n >= 8);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1;
    t_por;
    t_regs;
    t_halt;
    t_stop(8'h00, 2'd0, 0);
    t_stop(8'h20, 2'd0, 1);
    t_stop(8'h00, 2'd1, 1);
    t_stop(8'h00, 2'd2, 1);
    stop_test;
  end
endmodule // tb
